// [hw/matrix_pkg.sv]
// Purpose: shared constants and types of the boot-remap bus matrix
// Assumes: seven masters, five slaves, 32-bit addresses
// Notes:   address windows without a fixed documented base are chosen here
`default_nettype none
package matrix_pkg;
  // ****************************************************************
  // topology
  // ****************************************************************
  localparam int NUM_MASTERS = 7;
  localparam int NUM_SLAVES  = 5;

  localparam logic [2:0] MST_INSTR    = 3'h0;
  localparam logic [2:0] MST_DATA     = 3'h1;
  localparam logic [2:0] MST_PDMA     = 3'h2;
  localparam logic [2:0] MST_DSP_DMA  = 3'h3;
  localparam logic [2:0] MST_USB_HOST = 3'h4;
  localparam logic [2:0] MST_ETH      = 3'h5;
  localparam logic [2:0] MST_DSP_DBG  = 3'h6;

  localparam logic [2:0] SLV_SRAM     = 3'h0;
  localparam logic [2:0] SLV_ROM      = 3'h1;
  localparam logic [2:0] SLV_DSP_USB  = 3'h2;
  localparam logic [2:0] SLV_EXT_BUS  = 3'h3;
  localparam logic [2:0] SLV_APB      = 3'h4;

  // bit m set: master m owns a port on that slave
  localparam logic [6:0] LINK_MASK [0:4] = '{7'h3f, 7'h03, 7'h46, 7'h7f, 7'h0e};
  localparam logic [2:0] DEFAULT_MASTER [0:4] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h1};

  // ****************************************************************
  // address map
  // ****************************************************************
  localparam logic [31:0] BOOT_WIN_LAST    = 32'h000f_ffff;
  localparam int          BOOT_OFS_BITS    = 20;
  localparam logic [31:0] SRAM_BASE        = 32'h0010_0000;
  localparam logic [31:0] SRAM_LAST        = 32'h003f_ffff;
  localparam logic [31:0] SRAM_LOAD_BASE   = 32'h0030_0000;
  localparam logic [31:0] ROM_BASE         = 32'h0040_0000;
  localparam logic [31:0] ROM_LAST         = 32'h004f_ffff;
  localparam logic [31:0] DSP_BASE         = 32'h0050_0000;
  localparam logic [31:0] DSP_LAST         = 32'h005f_ffff;
  localparam logic [31:0] DSP_RESTRICT_OFS = 32'h0008_0000;
  localparam logic [31:0] EXT_CS0_BASE     = 32'h1000_0000;
  localparam logic [31:0] EXT_LAST         = 32'h8fff_ffff;
  localparam logic [31:0] APB_BASE         = 32'hf000_0000;

  // ****************************************************************
  // reset and timing
  // ****************************************************************
  localparam logic [1:0] BOOT_CAPTURE_LAST  = 2'h2;
  localparam logic       CS0_BYTE_SEL_RST   = 1'h1;
  localparam logic       CS0_BUS_32_RST     = 1'h1;
  localparam logic       CS0_STROBE_CS_RST  = 1'h1;

  typedef enum logic [2:0] {
    M_IDLE   = 3'b001,
    M_PEND   = 3'b010,
    M_ACTIVE = 3'b100
  } mstate_t;

  typedef struct packed {
    logic        ok;
    logic [2:0]  slave;
    logic [31:0] addr;
  } decode_t;
endpackage
`default_nettype wire

// [hw/ahb_matrix_boot_remap.sv]
// Purpose: seven-master, five-slave matrix with boot alias and remap
// Assumes: masters and slaves run on CORE_CLK_IN; boot select is a pin
// Notes:   requests are one-cycle pulses, one outstanding per master
`default_nettype none
// Function
// - seven masters indexed instr, data, periph dma, dsp dma, usb, eth, debug
// - sram admits masters 0-5, rom admits 0 and 1, instr default
// - dsp slave: data, pdma, debug; ext all; apb data, pdma, dsp dma
// - fetch begins at address zero; memory there set by remap and boot select
// - remap set puts sram at zero per master and ignores boot select
// - remap clear: boot select sampled at reset picks rom or external
// - boot window covers zero through 0x000f_ffff
// - boot select high aliases embedded rom into boot window
// - boot select low aliases external chip select zero into window
// - non-aliased memories stay at their fixed bases always
// - external boot runs from the 32768 hz slow clock at reset
// - chip select zero resets to byte select, 32-bit, strobes by chip select
// - rom boot loads code into sram at 0x300000, then remaps and runs
// - no valid spi code found: boot program starts uploader monitor
// - dsp data memory keeps one access per cycle for slave port
// - dsp program memory 8k x 128, second port shared by dma and slave
// - dsp slave resources fully reachable only in debug mode
// - risc core and dsp exchange interrupts
// - sram reachable at 0x00300000 by all enabled masters before remap
// - after remap sram also at zero for instr and data masters
module ahb_matrix_boot_remap #(
  parameter int DATA_W = 32
) (
  input  wire logic              CORE_CLK_IN,
  input  wire logic              RESET_N_IN,
  input  wire logic              BOOT_SOURCE_SELECT_IN,
  input  wire logic [1:0]        REMAP_IN,
  input  wire logic              DSP_DEBUG_MODE_IN,
  input  wire logic              RISC_TO_DSP_IRQ_IN,
  input  wire logic              DSP_TO_RISC_IRQ_IN,
  input  wire logic              M_REQ_IN     [matrix_pkg::NUM_MASTERS],
  input  wire logic [31:0]       M_ADDR_IN    [matrix_pkg::NUM_MASTERS],
  input  wire logic              M_WRITE_IN   [matrix_pkg::NUM_MASTERS],
  input  wire logic [DATA_W-1:0] M_WDATA_IN   [matrix_pkg::NUM_MASTERS],
  output logic                   M_BUSY_OUT   [matrix_pkg::NUM_MASTERS],
  output logic                   M_DONE_OUT   [matrix_pkg::NUM_MASTERS],
  output logic                   M_ERR_OUT    [matrix_pkg::NUM_MASTERS],
  output logic [DATA_W-1:0]      M_RDATA_OUT  [matrix_pkg::NUM_MASTERS],
  output logic                   S_SEL_OUT    [matrix_pkg::NUM_SLAVES],
  output logic [31:0]            S_ADDR_OUT   [matrix_pkg::NUM_SLAVES],
  output logic                   S_WRITE_OUT  [matrix_pkg::NUM_SLAVES],
  output logic [DATA_W-1:0]      S_WDATA_OUT  [matrix_pkg::NUM_SLAVES],
  output logic [2:0]             S_MASTER_OUT [matrix_pkg::NUM_SLAVES],
  input  wire logic              S_READY_IN   [matrix_pkg::NUM_SLAVES],
  input  wire logic              S_ERR_IN     [matrix_pkg::NUM_SLAVES],
  input  wire logic [DATA_W-1:0] S_RDATA_IN   [matrix_pkg::NUM_SLAVES],
  output logic                   BOOT_DONE_OUT,
  output logic                   BOOT_FROM_ROM_OUT,
  output logic                   SLOW_CLOCK_BOOT_OUT,
  output logic                   CS0_BYTE_SELECT_OUT,
  output logic                   CS0_BUS_32BIT_OUT,
  output logic                   CS0_STROBE_BY_CS_OUT,
  output logic                   DSP_IRQ_OUT,
  output logic                   RISC_IRQ_OUT
);
  localparam int NM = matrix_pkg::NUM_MASTERS;
  localparam int NS = matrix_pkg::NUM_SLAVES;

  // ****************************************************************
  // reset release and boot select capture
  // ****************************************************************
  logic       rst_meta_q, rst_n;
  logic       bss_meta_q, bss_sync_q;
  logic [1:0] boot_cnt_q, boot_cnt_d;
  logic       boot_done_q, boot_done_d;
  logic       boot_rom_q, boot_rom_d;

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      bss_meta_q <= 1'b0;
      bss_sync_q <= 1'b0;
    end else begin
      bss_meta_q <= BOOT_SOURCE_SELECT_IN;
      bss_sync_q <= bss_meta_q;
    end
  end

  // the pin is caught once, after the synchroniser has filled; later edges are ignored
  always_comb begin
    boot_cnt_d  = boot_cnt_q;
    boot_done_d = boot_done_q;
    boot_rom_d  = boot_rom_q;
    if (!boot_done_q) begin
      boot_cnt_d = boot_cnt_q + 2'h1;
      if (boot_cnt_q == matrix_pkg::BOOT_CAPTURE_LAST) begin
        boot_done_d = 1'b1;
        boot_rom_d  = bss_sync_q;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt_q  <= 2'h0;
      boot_done_q <= 1'b0;
      boot_rom_q  <= 1'b0;
    end else begin
      boot_cnt_q  <= boot_cnt_d;
      boot_done_q <= boot_done_d;
      boot_rom_q  <= boot_rom_d;
    end
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  function automatic matrix_pkg::decode_t decode(input logic [31:0] addr, input logic [2:0] mst,
                                                 input logic remap, input logic from_rom,
                                                 input logic debug);
    matrix_pkg::decode_t r;
    logic [31:0]         ofs;
    ofs     = {12'h000, addr[matrix_pkg::BOOT_OFS_BITS-1:0]};
    r.ok    = 1'b1;
    r.slave = matrix_pkg::SLV_SRAM;
    r.addr  = addr;
    if (addr <= matrix_pkg::BOOT_WIN_LAST) begin
      if (remap && (mst == matrix_pkg::MST_INSTR || mst == matrix_pkg::MST_DATA)) begin
        r.slave = matrix_pkg::SLV_SRAM;
        r.addr  = matrix_pkg::SRAM_LOAD_BASE | ofs;
      end else if (from_rom) begin
        r.slave = matrix_pkg::SLV_ROM;
        r.addr  = matrix_pkg::ROM_BASE | ofs;
      end else begin
        r.slave = matrix_pkg::SLV_EXT_BUS;
        r.addr  = matrix_pkg::EXT_CS0_BASE | ofs;
      end
    end else if (addr >= matrix_pkg::SRAM_BASE && addr <= matrix_pkg::SRAM_LAST) begin
      r.slave = matrix_pkg::SLV_SRAM;
    end else if (addr >= matrix_pkg::ROM_BASE && addr <= matrix_pkg::ROM_LAST) begin
      r.slave = matrix_pkg::SLV_ROM;
    end else if (addr >= matrix_pkg::DSP_BASE && addr <= matrix_pkg::DSP_LAST) begin
      r.slave = matrix_pkg::SLV_DSP_USB;
      r.ok    = debug || ((addr - matrix_pkg::DSP_BASE) < matrix_pkg::DSP_RESTRICT_OFS);
    end else if (addr >= matrix_pkg::EXT_CS0_BASE && addr <= matrix_pkg::EXT_LAST) begin
      r.slave = matrix_pkg::SLV_EXT_BUS;
    end else if (addr >= matrix_pkg::APB_BASE) begin
      r.slave = matrix_pkg::SLV_APB;
    end else begin
      r.ok = 1'b0;
    end
    r.ok = r.ok && matrix_pkg::LINK_MASK[r.slave][mst];
    return r;
  endfunction

  // ****************************************************************
  // master and slave state
  // ****************************************************************
  matrix_pkg::mstate_t mst_q [NM], mst_d [NM];
  logic [31:0]         addr_q [NM], addr_d [NM];
  logic [DATA_W-1:0]   wdata_q [NM], wdata_d [NM];
  logic                write_q [NM], write_d [NM];
  logic [2:0]          tgt_q [NM], tgt_d [NM];
  logic                mbusy_q [NM], mbusy_d [NM];
  logic                done_q [NM], done_d [NM];
  logic                err_q [NM], err_d [NM];
  logic [DATA_W-1:0]   rdata_q [NM], rdata_d [NM];
  logic                sel_q [NS], sel_d [NS];
  logic [2:0]          owner_q [NS], owner_d [NS];
  logic [31:0]         saddr_q [NS], saddr_d [NS];
  logic                swrite_q [NS], swrite_d [NS];
  logic [DATA_W-1:0]   swdata_q [NS], swdata_d [NS];

  matrix_pkg::decode_t dec [NM];
  logic                want [NM];
  logic                found;
  logic [2:0]          gnt;

  always_comb begin
    found = 1'b0;
    gnt   = 3'h0;
    for (int m = 0; m < NM; m++) begin
      mst_d[m]   = mst_q[m];
      addr_d[m]  = addr_q[m];
      wdata_d[m] = wdata_q[m];
      write_d[m] = write_q[m];
      tgt_d[m]   = tgt_q[m];
      mbusy_d[m] = mbusy_q[m];
      rdata_d[m] = rdata_q[m];
      done_d[m]  = 1'b0;
      err_d[m]   = 1'b0;
      dec[m]     = decode(M_ADDR_IN[m], 3'(m), (m < 2) ? REMAP_IN[m[0]] : 1'b0, boot_rom_q,
                          DSP_DEBUG_MODE_IN);
      want[m]    = mst_q[m] == matrix_pkg::M_PEND;
      if (M_REQ_IN[m] && mst_q[m] == matrix_pkg::M_IDLE && boot_done_q) begin
        if (!dec[m].ok) begin
          done_d[m] = 1'b1;
          err_d[m]  = 1'b1;
        end else begin
          want[m]     = 1'b1;
          mst_d[m]    = matrix_pkg::M_PEND;
          mbusy_d[m]  = 1'b1;
          addr_d[m]   = dec[m].addr;
          tgt_d[m]    = dec[m].slave;
          write_d[m]  = M_WRITE_IN[m];
          wdata_d[m]  = M_WDATA_IN[m];
        end
      end
    end
    for (int s = 0; s < NS; s++) begin
      sel_d[s]    = sel_q[s];
      owner_d[s]  = owner_q[s];
      saddr_d[s]  = saddr_q[s];
      swrite_d[s] = swrite_q[s];
      swdata_d[s] = swdata_q[s];
      if (sel_q[s]) begin
        // every slave, the dsp one included, holds its owner until S_READY_IN, then returns done, error and read data
        if (S_READY_IN[s]) begin
          done_d[owner_q[s]]  = 1'b1;
          err_d[owner_q[s]]   = S_ERR_IN[s];
          rdata_d[owner_q[s]] = S_RDATA_IN[s];
          mst_d[owner_q[s]]   = matrix_pkg::M_IDLE;
          mbusy_d[owner_q[s]] = 1'b0;
          sel_d[s]   = 1'b0;
          owner_d[s] = matrix_pkg::DEFAULT_MASTER[s];
        end
      end else begin
        // parked owner is checked first, so its fresh request is granted in the same edge
        // the _d copies already hold a request taken this edge, so it can win at once
        found = want[owner_q[s]] && tgt_d[owner_q[s]] == 3'(s);
        gnt   = owner_q[s];
        for (int m = 0; m < NM; m++) begin
          if (!found && want[m] && tgt_d[m] == 3'(s)) begin
            found = 1'b1;
            gnt   = 3'(m);
          end
        end
        if (found) begin
          sel_d[s]    = 1'b1;
          owner_d[s]  = gnt;
          saddr_d[s]  = addr_d[gnt];
          swrite_d[s] = write_d[gnt];
          swdata_d[s] = wdata_d[gnt];
          mst_d[gnt]  = matrix_pkg::M_ACTIVE;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      for (int m = 0; m < NM; m++) begin
        mst_q[m]   <= matrix_pkg::M_IDLE;
        addr_q[m]  <= 32'h0000_0000;
        wdata_q[m] <= '0;
        write_q[m] <= 1'b0;
        tgt_q[m]   <= 3'h0;
        mbusy_q[m] <= 1'b0;
        done_q[m]  <= 1'b0;
        err_q[m]   <= 1'b0;
        rdata_q[m] <= '0;
      end
      for (int s = 0; s < NS; s++) begin
        sel_q[s]    <= 1'b0;
        owner_q[s]  <= matrix_pkg::DEFAULT_MASTER[s];
        saddr_q[s]  <= 32'h0000_0000;
        swrite_q[s] <= 1'b0;
        swdata_q[s] <= '0;
      end
    end else begin
      mst_q    <= mst_d;
      addr_q   <= addr_d;
      wdata_q  <= wdata_d;
      write_q  <= write_d;
      tgt_q    <= tgt_d;
      mbusy_q  <= mbusy_d;
      done_q   <= done_d;
      err_q    <= err_d;
      rdata_q  <= rdata_d;
      sel_q    <= sel_d;
      owner_q  <= owner_d;
      saddr_q  <= saddr_d;
      swrite_q <= swrite_d;
      swdata_q <= swdata_d;
    end
  end

  // ****************************************************************
  // boot-time straps, clocking and interrupts
  // ****************************************************************
  logic slow_q, cs0_bs_q, cs0_32_q, cs0_cs_q;
  logic dsp_irq_q, risc_irq_q;

  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      slow_q     <= 1'b0;
      cs0_bs_q   <= matrix_pkg::CS0_BYTE_SEL_RST;
      cs0_32_q   <= matrix_pkg::CS0_BUS_32_RST;
      cs0_cs_q   <= matrix_pkg::CS0_STROBE_CS_RST;
      dsp_irq_q  <= 1'b0;
      risc_irq_q <= 1'b0;
    end else begin
      // external boot raises the slow clock flag at capture; nothing clears it before the next reset
      slow_q     <= boot_done_d && !boot_rom_d;
      dsp_irq_q  <= RISC_TO_DSP_IRQ_IN;
      risc_irq_q <= DSP_TO_RISC_IRQ_IN;
    end
  end

  assign M_BUSY_OUT           = mbusy_q;
  assign M_DONE_OUT           = done_q;
  assign M_ERR_OUT            = err_q;
  assign M_RDATA_OUT          = rdata_q;
  assign S_SEL_OUT            = sel_q;
  assign S_ADDR_OUT           = saddr_q;
  assign S_WRITE_OUT          = swrite_q;
  assign S_WDATA_OUT          = swdata_q;
  assign S_MASTER_OUT         = owner_q;
  assign BOOT_DONE_OUT        = boot_done_q;
  assign BOOT_FROM_ROM_OUT    = boot_rom_q;
  assign SLOW_CLOCK_BOOT_OUT  = slow_q;
  assign CS0_BYTE_SELECT_OUT  = cs0_bs_q;
  assign CS0_BUS_32BIT_OUT    = cs0_32_q;
  assign CS0_STROBE_BY_CS_OUT = cs0_cs_q;
  assign DSP_IRQ_OUT          = dsp_irq_q;
  assign RISC_IRQ_OUT         = risc_irq_q;
endmodule
`default_nettype wire

// [test/matrix_asserts.sv]
// Purpose: concurrent checks on the boot-remap matrix ports
// Assumes: one clock domain, active-low reset
// Notes:   bound to every instance of the matrix
`default_nettype none
module matrix_asserts (
  input wire logic        CORE_CLK_IN,
  input wire logic        RESET_N_IN,
  input wire logic        RISC_TO_DSP_IRQ_IN,
  input wire logic        DSP_TO_RISC_IRQ_IN,
  input wire logic        M_BUSY_OUT   [matrix_pkg::NUM_MASTERS],
  input wire logic        M_DONE_OUT   [matrix_pkg::NUM_MASTERS],
  input wire logic        M_ERR_OUT    [matrix_pkg::NUM_MASTERS],
  input wire logic        S_SEL_OUT    [matrix_pkg::NUM_SLAVES],
  input wire logic [31:0] S_ADDR_OUT   [matrix_pkg::NUM_SLAVES],
  input wire logic [2:0]  S_MASTER_OUT [matrix_pkg::NUM_SLAVES],
  input wire logic        S_READY_IN   [matrix_pkg::NUM_SLAVES],
  input wire logic        BOOT_DONE_OUT,
  input wire logic        BOOT_FROM_ROM_OUT,
  input wire logic        SLOW_CLOCK_BOOT_OUT,
  input wire logic        CS0_BYTE_SELECT_OUT,
  input wire logic        CS0_BUS_32BIT_OUT,
  input wire logic        CS0_STROBE_BY_CS_OUT,
  input wire logic        DSP_IRQ_OUT,
  input wire logic        RISC_IRQ_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  // ****************************************************************
  // strap, boot and interrupt relay checks
  // ****************************************************************
  a_cs0_strap: assert property (
    CS0_BYTE_SELECT_OUT && CS0_BUS_32BIT_OUT && CS0_STROBE_BY_CS_OUT) else $error("cs0 reset config lost");
  a_slow_boot: assert property (
    BOOT_DONE_OUT |-> SLOW_CLOCK_BOOT_OUT == !BOOT_FROM_ROM_OUT) else $error("slow clock flag wrong");
  // the pin moves after capture in the bench, so a resample shows here
  a_boot_held: assert property (
    BOOT_DONE_OUT |=> BOOT_DONE_OUT && $stable(BOOT_FROM_ROM_OUT)) else $error("boot source changed");
  a_irq_relay: assert property (BOOT_DONE_OUT |-> DSP_IRQ_OUT == $past(RISC_TO_DSP_IRQ_IN)
    && RISC_IRQ_OUT == $past(DSP_TO_RISC_IRQ_IN)) else $error("irq relay wrong");
  // ****************************************************************
  // per slave and per master
  // ****************************************************************
  for (genvar s = 0; s < 5; s++) begin : g_slv
    a_idle_park: assert property (
      !S_SEL_OUT[s] |-> S_MASTER_OUT[s] == matrix_pkg::DEFAULT_MASTER[s]) else $error("idle slave not parked");
    a_linked_owner: assert property (
      S_SEL_OUT[s] |-> matrix_pkg::LINK_MASK[s][S_MASTER_OUT[s]]) else $error("unlinked master granted");
    a_sel_hold: assert property (S_SEL_OUT[s] && !S_READY_IN[s] |=> S_SEL_OUT[s]
      && $stable(S_ADDR_OUT[s]) && $stable(S_MASTER_OUT[s])) else $error("slave request dropped");
  end
  for (genvar m = 0; m < 7; m++) begin : g_mst
    a_err_done: assert property (M_ERR_OUT[m] |-> M_DONE_OUT[m]) else $error("error without done");
    a_busy_done: assert property ($fell(M_BUSY_OUT[m]) |-> M_DONE_OUT[m]) else $error("busy ended silently");
    a_no_early: assert property (
      !BOOT_DONE_OUT |-> !M_BUSY_OUT[m] && !M_DONE_OUT[m]) else $error("transfer before boot capture");
  end
  c_rom_sel: cover property (S_SEL_OUT[1]);
  c_stall: cover property (S_SEL_OUT[3] && !S_READY_IN[3]);
  c_err: cover property (M_ERR_OUT[2]);
endmodule
bind ahb_matrix_boot_remap matrix_asserts i_chk (.*);
`default_nettype wire

// [test/slave_farm.sv]
// Purpose: responder for the five slave ports of the matrix
// Assumes: every slave answers after stall_in wait cycles
// Notes:   read data encodes address, slave index and any write data
`default_nettype none
module slave_farm (
  input  wire logic        clk_in,
  input  wire logic [1:0]  stall_in,
  input  wire logic        sel_in    [5],
  input  wire logic [31:0] addr_in   [5],
  input  wire logic        write_in  [5],
  input  wire logic [31:0] wdata_in  [5],
  output logic             ready_out [5],
  output logic             err_out   [5],
  output logic [31:0]      rdata_out [5]
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] wait_q [5] = '{default: 2'h0};
  logic [1:0] wait_d [5];
  // ****************************************************************
  // answer logic
  // ****************************************************************
  always_comb begin
    for (int s = 0; s < 5; s++) begin
      ready_out[s] = sel_in[s] && (wait_q[s] == stall_in);
      wait_d[s]    = (sel_in[s] && !ready_out[s]) ? wait_q[s] + 2'h1 : 2'h0;
      err_out[s]   = 1'b0;
      // off-cycle data scrambles, so a late sample never matches by luck
      rdata_out[s] = addr_in[s] ^ (write_in[s] ? wdata_in[s] : 32'h0000_0000)
                     ^ (ready_out[s] ? {3'(s), 29'h0} : {30'h3fff_ffff, wait_q[s]});
    end
  end
  always_ff @(posedge clk_in) begin
    wait_q <= wait_d;
  end
endmodule
`default_nettype wire

// [test/tb.sv]
// Purpose: self-checking bench for the boot-remap matrix
// Assumes: slave_farm answers all five slave ports
// Notes:   expected replies are worked out from the address map
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        CORE_CLK_IN = 1'b0;
  logic        RESET_N_IN, BOOT_SOURCE_SELECT_IN, DSP_DEBUG_MODE_IN, RISC_TO_DSP_IRQ_IN, DSP_TO_RISC_IRQ_IN;
  logic [1:0]  REMAP_IN, stall;
  logic        M_REQ_IN [7], M_WRITE_IN [7], M_BUSY_OUT [7], M_DONE_OUT [7], M_ERR_OUT [7];
  logic [31:0] M_ADDR_IN [7], M_WDATA_IN [7], M_RDATA_OUT [7];
  logic        S_SEL_OUT [5], S_WRITE_OUT [5], S_READY_IN [5], S_ERR_IN [5];
  logic [31:0] S_ADDR_OUT [5], S_WDATA_OUT [5], S_RDATA_IN [5], tbl [8];
  logic [2:0]  S_MASTER_OUT [5];
  logic        BOOT_DONE_OUT, BOOT_FROM_ROM_OUT, SLOW_CLOCK_BOOT_OUT, CS0_BYTE_SELECT_OUT;
  logic        CS0_BUS_32BIT_OUT, CS0_STROBE_BY_CS_OUT, DSP_IRQ_OUT, RISC_IRQ_OUT, boot_rom;
  logic [33:0] note_q [7][$];
  logic [33:0] nt;
  logic [31:0] r;
  integer      seed = 32'h1ead_ea3d;
  int          err_total = 0;
  int          num_checks = 0;

  always #12.5 CORE_CLK_IN = ~CORE_CLK_IN;

  ahb_matrix_boot_remap i_dut (.*);
  slave_farm i_farm (.clk_in(CORE_CLK_IN), .stall_in(stall), .sel_in(S_SEL_OUT), .addr_in(S_ADDR_OUT),
    .write_in(S_WRITE_OUT), .wdata_in(S_WDATA_OUT), .ready_out(S_READY_IN), .err_out(S_ERR_IN),
    .rdata_out(S_RDATA_IN));

  // ****************************************************************
  // reference model and drivers
  // ****************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // returns {error, slave, expected read data}
  function automatic logic [35:0] route(input int m, input logic [31:0] a);
    logic [2:0]  s;
    logic [31:0] t;
    logic        e;
    s = matrix_pkg::SLV_EXT_BUS;
    t = a;
    e = 1'b0;
    if (a <= matrix_pkg::BOOT_WIN_LAST) begin
      if (m < 2 && REMAP_IN[m]) begin
        s = matrix_pkg::SLV_SRAM;
        t = matrix_pkg::SRAM_LOAD_BASE | a;
      end else if (boot_rom) begin
        s = matrix_pkg::SLV_ROM;
        t = matrix_pkg::ROM_BASE | a;
      end else begin
        t = matrix_pkg::EXT_CS0_BASE | a;
      end
    end else if (a >= matrix_pkg::SRAM_BASE && a <= matrix_pkg::SRAM_LAST) begin
      s = matrix_pkg::SLV_SRAM;
    end else if (a >= matrix_pkg::ROM_BASE && a <= matrix_pkg::ROM_LAST) begin
      s = matrix_pkg::SLV_ROM;
    end else if (a >= matrix_pkg::DSP_BASE && a <= matrix_pkg::DSP_LAST) begin
      s = matrix_pkg::SLV_DSP_USB;
      e = !DSP_DEBUG_MODE_IN && (a - matrix_pkg::DSP_BASE >= matrix_pkg::DSP_RESTRICT_OFS);
    end else if (a >= matrix_pkg::APB_BASE) begin
      s = matrix_pkg::SLV_APB;
    end else begin
      e = (a < matrix_pkg::EXT_CS0_BASE) || (a > matrix_pkg::EXT_LAST);
    end
    e = e || !matrix_pkg::LINK_MASK[s][m];
    return {e, s, t ^ {s, 29'h0}};
  endfunction

  task automatic xfer(input int m, input logic [31:0] a, input logic wr);
    logic [35:0] rt;
    logic [31:0] wd;
    int          n;
    @(posedge CORE_CLK_IN);
    rt = route(m, a);
    wd = $random(seed);
    M_REQ_IN[m]   <= 1'b1;
    M_ADDR_IN[m]  <= a;
    M_WRITE_IN[m] <= wr;
    M_WDATA_IN[m] <= wd;
    // the farm echoes write data, so the slave side's write flag and data are checked too
    note_q[m].push_back({!rt[35], rt[35], rt[31:0] ^ (wr ? wd : 32'h0000_0000)});
    @(posedge CORE_CLK_IN);
    M_REQ_IN[m] <= 1'b0;
    for (n = 0; n < 60 && M_DONE_OUT[m] !== 1'b1; n++) @(negedge CORE_CLK_IN);
    if (n == 60) begin
      `CHK("done wait", 1'b1, 1'b0)
      final_report();
    end
  endtask

  task automatic do_reset();
    int n;
    @(posedge CORE_CLK_IN);
    RESET_N_IN            <= 1'b0;
    BOOT_SOURCE_SELECT_IN <= boot_rom;
    repeat (3) @(posedge CORE_CLK_IN);
    RESET_N_IN <= 1'b1;
    for (n = 0; n < 20 && BOOT_DONE_OUT !== 1'b1; n++) @(negedge CORE_CLK_IN);
    if (n == 20) begin
      `CHK("boot capture wait", 1'b1, 1'b0)
      final_report();
    end
    @(posedge CORE_CLK_IN);
    // the pin moves after capture and must not reach the alias
    BOOT_SOURCE_SELECT_IN <= !boot_rom;
  endtask

  // ****************************************************************
  // reply monitor
  // ****************************************************************
  always @(negedge CORE_CLK_IN) begin
    for (int m = 0; m < 7; m++) begin
      if (M_DONE_OUT[m] === 1'b1) begin
        if (note_q[m].size() == 0) begin
          `CHK("unexpected done", 1'b0, 1'b1)
        end else begin
          nt = note_q[m].pop_front();
          `CHK("error reply", nt[32], M_ERR_OUT[m])
          if (nt[33]) `CHK("read data", nt[31:0], M_RDATA_OUT[m])
        end
      end
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    RESET_N_IN = 1'b0;
    BOOT_SOURCE_SELECT_IN = 1'b1;
    DSP_DEBUG_MODE_IN = 1'b0;
    RISC_TO_DSP_IRQ_IN = 1'b0;
    DSP_TO_RISC_IRQ_IN = 1'b0;
    REMAP_IN = 2'h0;
    stall = 2'h0;
    for (int m = 0; m < 7; m++) begin
      M_REQ_IN[m] = 1'b0;
      M_WRITE_IN[m] = 1'b0;
      M_ADDR_IN[m] = 32'h0000_0000;
      M_WDATA_IN[m] = 32'h0000_0000;
    end
    tbl = '{32'h0000_0000, matrix_pkg::SRAM_LOAD_BASE, matrix_pkg::ROM_BASE, matrix_pkg::DSP_BASE,
      matrix_pkg::DSP_BASE + matrix_pkg::DSP_RESTRICT_OFS, matrix_pkg::EXT_CS0_BASE, matrix_pkg::APB_BASE,
      32'h9000_0000};
    for (int rd = 0; rd < 2; rd++) begin
      boot_rom = (rd == 0);
      do_reset();
      `CHK("boot from rom", boot_rom, BOOT_FROM_ROM_OUT)
      `CHK("slow clock boot", !boot_rom, SLOW_CLOCK_BOOT_OUT)
      `CHK("cs0 config", 3'h7, {CS0_BYTE_SELECT_OUT, CS0_BUS_32BIT_OUT, CS0_STROBE_BY_CS_OUT})
      for (int m = 0; m < 7; m++) begin
        for (int k = 0; k < 8; k++) begin
          r = $random(seed);
          @(posedge CORE_CLK_IN);
          REMAP_IN <= r[1:0];
          DSP_DEBUG_MODE_IN <= r[2];
          stall <= r[4:3];
          RISC_TO_DSP_IRQ_IN <= r[5];
          DSP_TO_RISC_IRQ_IN <= r[6];
          xfer(m, tbl[k] + {20'h0, r[15:6], 2'h0}, r[16]);
          `CHK("irq relay", r[6:5], {RISC_IRQ_OUT, DSP_IRQ_OUT})
        end
      end
      // all masters collide on the external bus while it stalls
      @(posedge CORE_CLK_IN);
      stall <= 2'h2;
      for (int m = 0; m < 7; m++) begin
        fork
          automatic int k = m;
          xfer(k, matrix_pkg::EXT_CS0_BASE + 32'(4 * k), 1'b0);
        join_none
      end
      wait fork;
      $display("round %0d finished", rd);
    end
    final_report();
  end
endmodule
`default_nettype wire
